// file: src/sps_pkg.sv
// sps_pkg: constants, register map and state type of the serial lane transmitter.
// assumes one 25 MHz clock and an APB master that programs the control register and reads status.
// How it works
// - 8-bit dual format: lanes 0-3 carry A0-A3, lanes 4-7 carry B0-B3.
// - 10-bit dual format: lane k carries samples k, k+4, k+8, k+12.
// - 12-bit quad format: channel pairs of lanes, even lane samples 0,2, odd 1,3.
// - 12-bit dual format: lane k carries samples k and k+4 in three octets.
// - sync header error check is 12-bit CRC only, no 3-bit CRC choice.
// - forward error correction is the other sync header choice.
// - redundant lane output only for formats using four lanes or fewer.
// - alternate select 0 drives lanes 0-3, 1 moves same data to lanes 4-7.
// - in four-lane formats only one lane group runs at a time, never both.
// - power-down pin high disables all serial drivers; mode register can too.
// - register settings are kept through power-down.
// - channel enables act on channel pairs, not single channels.
// - test select picks which serializer test pattern replaces normal data.
// - active lanes and rate follow the lane format in every test mode.
// - PRBS patterns bypass transport and link layers, unscrambled and unencoded.
// - every lane's PRBS starts from a different phase.
// - PRBS7 bit is XOR of bits 6 and 7 back, period 127.
// - PRBS9 taps 5 and 9; PRBS15 taps 14 and 15.
// - PRBS23 taps 18 and 23; PRBS31 taps 28 and 31.
package sps_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int NUM_LANES  = 8;
    localparam int GRP_W      = 4;
    localparam int NUM_CH     = 4;
    localparam int SMP_PER_CH = 16;
    localparam int SMP_W      = 12;
    localparam int OCT_W      = 8;
    localparam int S10_W      = 10;
    localparam int LANE_W     = 40;
    localparam int SMP_BUS_W  = NUM_CH * SMP_PER_CH * SMP_W;
    localparam int ADDR_W     = 8;
    localparam int FMT_W      = 4;
    localparam int TEST_W     = 3;
    localparam int PRBS_W     = 31;
    localparam int TAP_W      = 5;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam int CF_FMT_LSB  = 0;
    localparam int CF_LINK_EN  = 4;
    localparam int CF_FEC      = 5;
    localparam int CF_ALT      = 6;
    localparam int CF_PD       = 7;
    localparam int CF_PAIR_LSB = 8;
    localparam int CF_TEST_LSB = 12;
    localparam int SF_STATE    = 0;
    localparam int SF_PD       = 3;
    localparam int SF_MASK_LSB = 8;
    localparam logic [FMT_W-1:0]  RST_FMT  = 4'hC;
    localparam logic [1:0]        RST_PAIR = 2'h3;
    // ****************************************
    // lane formats and test selections
    // ****************************************
    localparam logic [FMT_W-1:0] FMT_8B_4L    = 4'h7;
    localparam logic [FMT_W-1:0] FMT_12B_4L   = 4'h8;
    localparam logic [FMT_W-1:0] FMT_8B_DUAL  = 4'hC;
    localparam logic [FMT_W-1:0] FMT_10B_DUAL = 4'hD;
    localparam logic [FMT_W-1:0] FMT_12B_QUAD = 4'hE;
    localparam logic [FMT_W-1:0] FMT_12B_DUAL = 4'hF;
    localparam logic [NUM_LANES-1:0] MASK_ALL = 8'hFF;
    localparam logic [NUM_LANES-1:0] MASK_DEF = 8'h0F;
    localparam logic [NUM_LANES-1:0] MASK_ALT = 8'hF0;
    localparam logic [TEST_W-1:0] TST_NONE   = 3'h0;
    localparam logic [TEST_W-1:0] TST_PRBS7  = 3'h1;
    localparam logic [TEST_W-1:0] TST_PRBS9  = 3'h2;
    localparam logic [TEST_W-1:0] TST_PRBS15 = 3'h3;
    localparam logic [TEST_W-1:0] TST_PRBS23 = 3'h4;
    localparam logic [TEST_W-1:0] TST_PRBS31 = 3'h5;
    localparam logic [TAP_W-1:0] P7_A  = 5'h06;
    localparam logic [TAP_W-1:0] P7_B  = 5'h07;
    localparam logic [TAP_W-1:0] P9_A  = 5'h05;
    localparam logic [TAP_W-1:0] P9_B  = 5'h09;
    localparam logic [TAP_W-1:0] P15_A = 5'h0E;
    localparam logic [TAP_W-1:0] P15_B = 5'h0F;
    localparam logic [TAP_W-1:0] P23_A = 5'h12;
    localparam logic [TAP_W-1:0] P23_B = 5'h17;
    localparam logic [TAP_W-1:0] P31_A = 5'h1C;
    localparam logic [TAP_W-1:0] P31_B = 5'h1F;
    typedef enum logic [2:0] {
        ST_DOWN = 3'h1,
        ST_IDLE = 3'h2,
        ST_RUN  = 3'h4
    } sps_state_t;
endpackage

// file: src/sps_prbs_lane.sv
// sps_prbs_lane: parallel PRBS generator for one lane, LANE_W bits per clock.
// assumes the test selection only changes while the link is down.
`timescale 1ns/1ps
module sps_prbs_lane
    import sps_pkg::*;
#(
    parameter logic [PRBS_W-1:0] SEED = PRBS_W'(1)
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    input  wire logic              ce_in,
    // selection
    input  wire logic [TEST_W-1:0] test_sel_in,
    // pattern, earliest bit in the msb
    output logic      [LANE_W-1:0] bits_out
);
    logic [PRBS_W-1:0] lfsr_q;
    logic [PRBS_W-1:0] lfsr_d;
    logic [LANE_W-1:0] bits_q;
    logic [LANE_W-1:0] bits_d;
    logic [TEST_W-1:0] mode_q;
    logic [TAP_W-1:0]  tap_a_w;
    logic [TAP_W-1:0]  tap_b_w;
    wire               restart_w;

    // a new selection, or none selected, reloads the seed, so a running stream never breaks
    assign restart_w = (test_sel_in != mode_q) || (test_sel_in == TST_NONE);
    assign tap_a_w   = (mode_q == TST_PRBS9)  ? P9_A  :
                       (mode_q == TST_PRBS15) ? P15_A :
                       (mode_q == TST_PRBS23) ? P23_A :
                       (mode_q == TST_PRBS31) ? P31_A : P7_A;
    assign tap_b_w   = (mode_q == TST_PRBS9)  ? P9_B  :
                       (mode_q == TST_PRBS15) ? P15_B :
                       (mode_q == TST_PRBS23) ? P23_B :
                       (mode_q == TST_PRBS31) ? P31_B : P7_B;
    assign bits_out  = bits_q;

    // lfsr bit 0 is the newest bit sent
    always_comb begin
        lfsr_d = lfsr_q;
        bits_d = '0;
        for (int i = LANE_W - 1; i >= 0; i--) begin
            bits_d[i] = lfsr_d[tap_a_w - 5'h01] ^ lfsr_d[tap_b_w - 5'h01];
            lfsr_d    = {lfsr_d[PRBS_W-2:0], bits_d[i]};
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lfsr_q <= SEED;
            bits_q <= '0;
            mode_q <= TST_NONE;
        end else if (ce_in) begin
            mode_q <= test_sel_in;
            lfsr_q <= restart_w ? SEED : lfsr_d;
            bits_q <= restart_w ? '0 : bits_d;
        end
    end
endmodule // sps_prbs_lane

// file: src/sps_lane_tx.sv
// sps_lane_tx: sample-to-lane packing, lane group choice, power-down and
// serializer test patterns of an eight-lane converter transmitter.
// assumes samples_in holds a whole frame, msb-aligned 12-bit words,
// and the serializers and line coders sit after lane_data_out.
`timescale 1ns/1ps
module sps_lane_tx
    import sps_pkg::*;
(
    // clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          reset_n_in,
    input  wire logic                          ce_in,
    // apb slave
    input  wire logic                          psel_in,
    input  wire logic                          penable_in,
    input  wire logic                          pwrite_in,
    input  wire logic [ADDR_W-1:0]             paddr_in,
    input  wire logic [31:0]                   pwdata_in,
    output logic      [31:0]                   prdata_out,
    output logic                               pready_out,
    output logic                               pslverr_out,
    // pins and samples
    input  wire logic                          power_down_pin_in,
    input  wire logic [SMP_BUS_W-1:0]          samples_in,
    // lanes
    output logic      [NUM_LANES*LANE_W-1:0]   lane_data_out,
    output logic      [NUM_LANES-1:0]          lane_drv_en_out,
    output logic                               lane_valid_out,
    // link status
    output logic                               sync_hdr_fec_out,
    output logic                               link_active_out,
    output logic      [1:0]                    chan_pair_on_out
);
    // ****************************************
    // registers
    // ****************************************
    logic [FMT_W-1:0]            fmt_q;
    logic [TEST_W-1:0]           test_q;
    logic [1:0]                  pair_q;
    logic                        link_en_q;
    logic                        fec_q;
    logic                        alt_q;
    logic                        pd_q;
    logic                        pready_q;
    logic                        pslverr_q;
    logic [31:0]                 prdata_q;
    sps_state_t                  state_q;
    sps_state_t                  state_d;
    logic [NUM_LANES*LANE_W-1:0] lane_data_q;
    logic [NUM_LANES-1:0]        lane_drv_q;
    logic                        lane_valid_q;
    logic [1:0]                  pair_on_q;
    logic                        link_act_q;

    // ****************************************
    // apb decode
    // ****************************************
    wire        pd_w;
    wire        setup_w    = psel_in && !penable_in;
    wire        acc_w      = psel_in && penable_in && pready_q;
    wire        ctrl_hit_w = (paddr_in == REG_CTRL);
    wire        stat_hit_w = (paddr_in == REG_STATUS);
    wire        map_hit_w  = ctrl_hit_w || stat_hit_w;
    wire        wr_ctrl_w  = acc_w && pwrite_in && ctrl_hit_w;
    wire [31:0] ctrl_word_w;
    wire [31:0] stat_word_w;
    wire [31:0] rdata_w;

    assign ctrl_word_w = (32'(fmt_q) << CF_FMT_LSB) | (32'(link_en_q) << CF_LINK_EN)
                       | (32'(fec_q) << CF_FEC) | (32'(alt_q) << CF_ALT)
                       | (32'(pd_q) << CF_PD) | (32'(pair_q) << CF_PAIR_LSB)
                       | (32'(test_q) << CF_TEST_LSB);
    assign stat_word_w = (32'(state_q) << SF_STATE) | (32'(pd_w) << SF_PD)
                       | (32'(lane_drv_q) << SF_MASK_LSB);
    assign rdata_w     = ctrl_hit_w ? ctrl_word_w :
                         stat_hit_w ? stat_word_w : 32'h0000_0000;

    // ****************************************
    // lane format and groups
    // ****************************************
    wire                 dual_w;
    wire                 quad_w;
    wire                 fmt8l_w;
    wire                 fmt4l_w;
    wire                 alt_on_w;
    wire                 test_on_w;
    wire [NUM_LANES-1:0] mask_w;

    // pin or mode register, either one shuts the drivers
    assign pd_w      = power_down_pin_in || pd_q;
    assign dual_w    = (fmt_q == FMT_8B_DUAL) || (fmt_q == FMT_10B_DUAL)
                     || (fmt_q == FMT_12B_DUAL);
    assign quad_w    = (fmt_q == FMT_12B_QUAD);
    assign fmt8l_w   = dual_w || quad_w;
    assign fmt4l_w   = (fmt_q == FMT_8B_4L) || (fmt_q == FMT_12B_4L);
    // redundancy only makes sense where four spare lanes exist
    assign alt_on_w  = fmt4l_w && alt_q;
    // test modes keep the lane count of the chosen format
    assign mask_w    = fmt8l_w  ? MASK_ALL :
                       alt_on_w ? MASK_ALT :
                       fmt4l_w  ? MASK_DEF : '0;
    assign test_on_w = (test_q != TST_NONE);

    // ****************************************
    // per-lane packing
    // ****************************************
    function automatic logic [SMP_W-1:0] smp(input logic [SMP_BUS_W-1:0] v,
                                             input int c, input int s);
        smp = v[(c * SMP_PER_CH + s) * SMP_W +: SMP_W];
    endfunction

    logic [LANE_W-1:0]           pack_w [NUM_LANES];
    logic [LANE_W-1:0]           prbs_w [NUM_LANES];
    logic [NUM_LANES*LANE_W-1:0] data_w;

    for (genvar L = 0; L < NUM_LANES; L++) begin : g_lane
        localparam int DC  = L / GRP_W;
        localparam int DI  = L % GRP_W;
        localparam int QC  = L / 2;
        localparam int QI  = L % 2;
        localparam int SRC = (L >= GRP_W) ? L - GRP_W : L;
        wire [SMP_W-1:0]  d0_w = smp(samples_in, DC, DI);
        wire [SMP_W-1:0]  d1_w = smp(samples_in, DC, DI + GRP_W);
        wire [SMP_W-1:0]  d2_w = smp(samples_in, DC, DI + 2 * GRP_W);
        wire [SMP_W-1:0]  d3_w = smp(samples_in, DC, DI + 3 * GRP_W);
        wire [SMP_W-1:0]  q0_w = smp(samples_in, QC, QI);
        wire [SMP_W-1:0]  q1_w = smp(samples_in, QC, QI + 2);
        wire [SMP_W-1:0]  f0_w = smp(samples_in, DI, 0);
        wire [SMP_W-1:0]  f1_w = smp(samples_in, DI, 1);
        wire [1:0]        src_ch_w;
        wire              pair_on_w;
        wire [LANE_W-1:0] sel_w;

        assign pack_w[L] =
            (fmt_q == FMT_8B_DUAL)  ? {d0_w[SMP_W-1 -: OCT_W],
                                       {(LANE_W - OCT_W){1'b0}}} :
            (fmt_q == FMT_10B_DUAL) ? {d0_w[SMP_W-1 -: S10_W], d1_w[SMP_W-1 -: S10_W],
                                       d2_w[SMP_W-1 -: S10_W],
                                       d3_w[SMP_W-1 -: S10_W]} :
            quad_w                  ? {q0_w, q1_w, {(LANE_W - 2 * SMP_W){1'b0}}} :
            (fmt_q == FMT_12B_DUAL) ? {d0_w, d1_w, {(LANE_W - 2 * SMP_W){1'b0}}} :
            (fmt_q == FMT_12B_4L)   ? {f0_w, f1_w, {(LANE_W - 2 * SMP_W){1'b0}}} :
            (fmt_q == FMT_8B_4L)    ? {f0_w[SMP_W-1 -: OCT_W],
                                       {(LANE_W - OCT_W){1'b0}}} : '0;

        // outside test modes a lane goes quiet when the pair feeding it is powered down
        assign src_ch_w  = quad_w ? 2'(QC) : dual_w ? 2'(DC) : 2'(DI);
        assign pair_on_w = pair_q[src_ch_w[1]];
        // upper group repeats the lower group's words
        assign sel_w     = (alt_on_w && L >= GRP_W) ? pack_w[SRC] : pack_w[L];

        sps_prbs_lane #(
            .SEED        (PRBS_W'(L + 1))
        ) u_prbs (
            .clk_in      (clk_in),
            .reset_n_in  (reset_n_in),
            .ce_in       (ce_in),
            .test_sel_in (test_q),
            .bits_out    (prbs_w[L])
        );

        // prbs goes straight to the lane: no scrambler, no coder in between
        assign data_w[L*LANE_W +: LANE_W] =
            !mask_w[L] ? '0 :
            test_on_w  ? prbs_w[L] :
            pair_on_w  ? sel_w : '0;
    end

    // ****************************************
    // link state
    // ****************************************
    // leaving power-down always passes idle, so the far end must relink
    always_comb begin
        case (state_q)
            ST_DOWN: state_d = pd_w ? ST_DOWN : ST_IDLE;
            ST_IDLE: state_d = pd_w ? ST_DOWN : link_en_q ? ST_RUN : ST_IDLE;
            ST_RUN:  state_d = pd_w ? ST_DOWN : link_en_q ? ST_RUN : ST_IDLE;
            default: state_d = ST_DOWN;
        endcase
    end

    // ****************************************
    // flops
    // ****************************************
    // settings live outside any power-down path
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fmt_q     <= RST_FMT;
            test_q    <= TST_NONE;
            pair_q    <= RST_PAIR;
            link_en_q <= 1'b0;
            fec_q     <= 1'b0;
            alt_q     <= 1'b0;
            pd_q      <= 1'b0;
        end else if (ce_in && wr_ctrl_w) begin
            fmt_q     <= pwdata_in[CF_FMT_LSB +: FMT_W];
            pair_q    <= pwdata_in[CF_PAIR_LSB +: 2];
            link_en_q <= pwdata_in[CF_LINK_EN];
            fec_q     <= pwdata_in[CF_FEC];
            alt_q     <= pwdata_in[CF_ALT];
            pd_q      <= pwdata_in[CF_PD];
            // a live link keeps its test selection
            if (!link_en_q) begin
                test_q <= pwdata_in[CF_TEST_LSB +: TEST_W];
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (ce_in) begin
            pready_q  <= setup_w;
            pslverr_q <= setup_w && !map_hit_w;
            if (setup_w && !pwrite_in) begin
                prdata_q <= rdata_w;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q      <= ST_DOWN;
            lane_data_q  <= '0;
            lane_drv_q   <= '0;
            lane_valid_q <= 1'b0;
            pair_on_q    <= '0;
            link_act_q   <= 1'b0;
        end else if (ce_in) begin
            state_q      <= state_d;
            lane_data_q  <= pd_w ? '0 : data_w;
            lane_drv_q   <= pd_w ? '0 : mask_w;
            lane_valid_q <= !pd_w && (test_on_w || state_q == ST_RUN);
            pair_on_q    <= pd_w ? 2'h0 : pair_q;
            link_act_q   <= (state_d == ST_RUN);
        end
    end

    assign prdata_out       = prdata_q;
    assign pready_out       = pready_q;
    assign pslverr_out      = pslverr_q;
    assign lane_data_out    = lane_data_q;
    assign lane_drv_en_out  = lane_drv_q;
    assign lane_valid_out   = lane_valid_q;
    assign sync_hdr_fec_out = fec_q;
    assign link_active_out  = link_act_q;
    assign chan_pair_on_out = pair_on_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    wire norm_w = ce_in && !test_on_w && !pd_w && pair_q[0];

    fmt8_map_a: assert property (
        norm_w && fmt_q == FMT_8B_DUAL
        |=> lane_data_q[39:32] == $past(samples_in[11:4])
            && lane_data_q[199:192] == $past(samples_in[203:196]))
        else $error("8-bit dual lane map wrong");
    fmt10_map_a: assert property (
        norm_w && fmt_q == FMT_10B_DUAL
        |=> lane_data_q[69:60] == $past(samples_in[71:62])
            && lane_data_q[49:40] == $past(samples_in[167:158]))
        else $error("10-bit dual lane map wrong");
    fmt12q_map_a: assert property (
        norm_w && quad_w
        |=> lane_data_q[159:148] == $past(samples_in[215:204])
            && lane_data_q[147:136] == $past(samples_in[239:228]))
        else $error("12-bit quad lane map wrong");
    fmt12d_map_a: assert property (
        norm_w && fmt_q == FMT_12B_DUAL
        |=> lane_data_q[279:268] == $past(samples_in[227:216])
            && lane_data_q[267:256] == $past(samples_in[275:264]))
        else $error("12-bit dual lane map wrong");
    sync_mode_a: assert property (
        ce_in && wr_ctrl_w |=> sync_hdr_fec_out == $past(pwdata_in[CF_FEC]))
        else $error("sync header mode not taken");
    lane_count_a: assert property (
        ce_in && fmt8l_w && !pd_w |=> lane_drv_en_out == MASK_ALL)
        else $error("eight-lane format lost lanes");
    one_group_a: assert property (
        ce_in && fmt4l_w && !pd_w
        |=> lane_drv_en_out == ($past(alt_q) ? MASK_ALT : MASK_DEF))
        else $error("wrong lane group driven");
    pd_drivers_a: assert property (
        ce_in && power_down_pin_in |=> lane_drv_en_out == '0 && lane_data_out == '0)
        else $error("drivers on during power-down");
    pd_keep_a: assert property (
        power_down_pin_in && !wr_ctrl_w
        |=> $stable(fmt_q) && $stable(pair_q) && $stable(test_q))
        else $error("settings lost in power-down");
    pair_off_a: assert property (
        ce_in && quad_w && !test_on_w && !pair_q[1] |=> lane_data_q[319:160] == '0)
        else $error("disabled pair still sends");
    test_hold_a: assert property (
        link_en_q && $past(link_en_q) |-> $stable(test_q))
        else $error("test select moved on live link");
    prbs_lane_a: assert property (
        ce_in && test_on_w && mask_w[0] && !pd_w |=> lane_data_q[39:0] == $past(prbs_w[0]))
        else $error("lane not carrying raw prbs");
    prbs_phase_a: assert property (
        test_q == TST_PRBS7 && $past(test_q, 3) == TST_PRBS7 |-> prbs_w[0] != prbs_w[1])
        else $error("two lanes share a prbs phase");
    prbs7_taps_a: assert property (
        test_q == TST_PRBS7 && $past(test_q, 3) == TST_PRBS7
        |-> prbs_w[2][0] == (prbs_w[2][6] ^ prbs_w[2][7]))
        else $error("prbs7 recursion broken");
    prbs9_taps_a: assert property (
        test_q == TST_PRBS9 && $past(test_q, 3) == TST_PRBS9
        |-> prbs_w[3][0] == (prbs_w[3][5] ^ prbs_w[3][9]))
        else $error("prbs9 recursion broken");
    prbs31_taps_a: assert property (
        test_q == TST_PRBS31 && $past(test_q, 3) == TST_PRBS31
        |-> prbs_w[4][0] == (prbs_w[4][28] ^ prbs_w[4][31]))
        else $error("prbs31 recursion broken");
    prbs_flow_a: assert property (
        ce_in && test_q == TST_PRBS7 && $past(test_q, 3) == TST_PRBS7
        |=> prbs_w[0][39] == ($past(prbs_w[0][5]) ^ $past(prbs_w[0][6])))
        else $error("prbs stream restarted");

    run_10b_c: cover property (state_q == ST_RUN && fmt_q == FMT_10B_DUAL);
    alt_used_c: cover property (alt_on_w && lane_drv_en_out == MASK_ALT);
    prbs31_c: cover property (test_q == TST_PRBS31 && lane_valid_out);
    pd_exit_c: cover property (state_q == ST_DOWN ##1 state_q == ST_IDLE);
endmodule // sps_lane_tx

// file: dv/sps_rx_model.sv
// sps_rx_model: far-side receiver that checks one lane's PRBS7 stream.
// assumes earliest bit in the word msb and one word per enabled clock.
`timescale 1ns/1ps
module sps_rx_model (
    // clock and stream
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        valid_in,
    input  wire logic [39:0] word_in,
    // results
    output int               errs_out,
    output int               words_out
);
    logic [79:0] hist = '0;
    logic        have = 1'b0;
    int          n;
    initial errs_out = 0;
    initial words_out = 0;
    always @(posedge clk_in) begin
        hist = {hist[39:0], word_in};
        // drop stale words until the lane is valid again
        if (!reset_n_in || !valid_in) have = 1'b0;
        else begin
            if (have) begin
                for (n = 0; n < 40; n++)
                    if (hist[n] !== (hist[n+6] ^ hist[n+7])) errs_out++;
                words_out++;
            end
            have = 1'b1;
        end
    end
endmodule // sps_rx_model

// file: dv/test_sps_lane_tx.sv
// test_sps_lane_tx: self-checking bench for sps_lane_tx.
// assumes zero-wait APB answers and the receiver model on lane 0.
`timescale 1ns/1ps
module test_sps_lane_tx
    import sps_pkg::*;
;
    logic clk_in = 0, reset_n_in = 0, psel = 0, penable = 0, pwrite = 0, pd = 0, rx_on = 0, err;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, rd;
    logic [SMP_BUS_W-1:0] smp = '0;
    wire [31:0] prdata;
    wire pready, pslverr, lvalid, act, fec;
    wire [1:0] pon;
    wire [NUM_LANES*LANE_W-1:0] lanes;
    wire [NUM_LANES-1:0] drv;
    int n_fail = 0, checks_done = 0, cyc = 0, errs, words;
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) if (++cyc > 2000) begin
        n_fail++;
        close_out();
    end
    sps_lane_tx dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .power_down_pin_in(pd), .samples_in(smp), .lane_data_out(lanes),
        .lane_drv_en_out(drv), .lane_valid_out(lvalid), .sync_hdr_fec_out(fec),
        .link_active_out(act), .chan_pair_on_out(pon));
    sps_rx_model rx (.clk_in(clk_in), .reset_n_in(reset_n_in), .valid_in(lvalid && rx_on),
        .word_in(lanes[39:0]), .errs_out(errs), .words_out(words));
    task close_out();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task t_pack();
        for (int i = 0; i < 64; i++) smp[i*12 +: 12] <= 12'(i * 16 + 3);
        apb(1, REG_CTRL, 32'h11C);
        apb(1, REG_CTRL, 32'h131C);
        apb(0, REG_CTRL, 0);
        check(rd, 32'h031C);
        repeat (3) @(posedge clk_in);
        for (int k = 0; k < 8; k++) check(lanes[k*40 +: 40], {8'(k < 4 ? k : 12 + k), 32'h0});
        check(drv, MASK_ALL);
    endtask
    task t_pwrdn();
        pd <= 1'b1;
        repeat (3) @(posedge clk_in);
        check({lvalid, drv}, 0);
        pd <= 1'b0;
        apb(0, REG_CTRL, 0);
        check(rd, 32'h031C);
    endtask
    task t_alt();
        apb(1, REG_CTRL, 32'h357);
        repeat (3) @(posedge clk_in);
        check(drv, MASK_ALT);
        check(lanes[5*40 +: 40], {8'h10, 32'h0});
    endtask
    function automatic logic [11:0] sv(input int c, input int s);
        return 12'((c * 16 + s) * 16 + 3);
    endfunction
    function automatic int prbs_bad(input logic [39:0] w, input int m);
        int a, b;
        a = m == 2 ? P9_A : m == 3 ? P15_A : m == 4 ? P23_A : P31_A;
        b = m == 2 ? P9_B : m == 3 ? P15_B : m == 4 ? P23_B : P31_B;
        prbs_bad = int'(w == '0);
        for (int n = 0; n + b < 40; n++) prbs_bad += int'(w[n] != (w[n + a] ^ w[n + b]));
    endfunction
    task t_fmt();
        apb(1, REG_CTRL, 32'h33D);
        repeat (3) @(posedge clk_in);
        check(lanes[40 +: 40], {10'(sv(0, 1) >> 2), 10'(sv(0, 5) >> 2), 10'(sv(0, 9) >> 2),
            10'(sv(0, 13) >> 2)});
        check({act, fec}, 2'b11);
        apb(0, REG_STATUS, 0);
        check(rd, 32'hFF04);
        apb(1, REG_CTRL, 32'h11E);
        repeat (3) @(posedge clk_in);
        check(lanes[3*40 +: 40], {sv(1, 1), sv(1, 3), 16'h0});
        check({pon, lanes[6*40 +: 40]}, {2'h1, 40'h0});
        apb(1, REG_CTRL, 32'h31F);
        repeat (3) @(posedge clk_in);
        check(lanes[6*40 +: 40], {sv(1, 2), sv(1, 6), 16'h0});
        apb(1, REG_CTRL, 32'h318);
        repeat (3) @(posedge clk_in);
        check({drv, lanes[2*40 +: 40]}, {MASK_DEF, sv(2, 0), sv(2, 1), 16'h0});
        apb(1, REG_CTRL, 32'h398);
        repeat (3) @(posedge clk_in);
        apb(0, REG_STATUS, 0);
        check({rd, drv, pon, act}, {32'h9, 11'h0});
    endtask
    task t_prbs();
        apb(1, REG_CTRL, 32'h30C);
        apb(1, REG_CTRL, 32'h130C);
        repeat (8) @(posedge clk_in);
        rx_on <= 1'b1;
        repeat (20) @(posedge clk_in);
        check(errs, 0);
        check(words > 10, 1);
        check(lanes[39:0] === lanes[79:40], 0);
        rx_on <= 1'b0;
        for (int m = 2; m < 6; m++) begin
            apb(1, REG_CTRL, 32'h30C | (m << 12));
            repeat (6) @(posedge clk_in);
            check(prbs_bad(lanes[39:0], m), 0);
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        apb(0, REG_CTRL, 0);
        check(rd, 32'h030C);
        apb(1, 8'h08, 32'hFF);
        check(err, 1'b1);
        t_pack();
        t_pwrdn();
        t_alt();
        t_fmt();
        t_prbs();
        close_out();
    end
endmodule // test_sps_lane_tx
